// ---- logic/iceb_pkg.sv ----
// package: constants and types for the interrupt clear-enable bank
package iceb_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFF_DISABLE_TWO = 12'h000;
  localparam logic [11:0] OFF_ENABLE_TWO  = 12'h004;
  localparam logic [31:0] RESET_ENABLE    = 32'h0000_0000;
  localparam logic [31:0] RESET_RDATA     = 32'h0000_0000;

  // ---------------------------------------------------------------
  // field layout: lines 32..59 on bits 27:26, 23:5, 3:0
  // ---------------------------------------------------------------
  localparam logic [31:0] IMPL_MASK  = 32'h0CFF_FFEF;
  localparam logic [31:0] HIGH_PAIR  = 32'h0C00_0000;
  localparam logic [31:0] MID_FIELD  = 32'h00FF_FFE0;
  localparam logic [31:0] LOW_FIELD  = 32'h0000_000F;

  // register bus request group from the bus master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } iceb_bus_req_t;

endpackage : iceb_pkg

// ---- logic/iceb_clear_bank.sv ----
// module: clear-enable bank for interrupt lines 32 to 59, register slave
//
// The APB slave port and the placing of the registers were decided locally.
module iceb_clear_bank
  import iceb_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // register bus slave
  input  wire iceb_bus_req_t bus_req,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // companion set-enable bank, one-cycle pulses per bit
  input  wire logic [31:0]   irq_enable_set_bits,
  // per-interrupt enables, bit n is line 32 + n
  output logic [31:0]        irq_enable
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // a transfer is setup, first access cycle, then the ready cycle;
  // the fixed wait state gives the read data a whole cycle to settle
  // and keeps the answer timing the same for every offset;
  // the whole offset field is compared, so aliases answer with an error
  logic        access;
  logic        done;
  logic        hit_clr;
  logic        hit_set;
  logic        wr_clr;
  logic        wr_set;
  logic [31:0] clr_word;
  logic [31:0] set_word;
  logic [31:0] next_enable;

  // access phase, and its completing edge
  assign access  = bus_req.psel & bus_req.penable;
  assign done    = access & pready;
  assign hit_clr = (bus_req.paddr == OFF_DISABLE_TWO);
  assign hit_set = (bus_req.paddr == OFF_ENABLE_TWO);
  assign wr_clr  = done & bus_req.pwrite & hit_clr;
  assign wr_set  = done & bus_req.pwrite & hit_set;

  // ---------------------------------------------------------------
  // enable flops
  // ---------------------------------------------------------------
  // holes masked off
  // unimplemented positions never reach an enable;
  // the words are gated by the completing edge, so a write that is
  // still waiting for ready cannot touch the enables
  assign clr_word = wr_clr ? (bus_req.pwdata & IMPL_MASK) : 32'h0000_0000;
  assign set_word = (irq_enable_set_bits
                  | (wr_set ? bus_req.pwdata : 32'h0000_0000)) & IMPL_MASK;

  // zero keeps state
  // a set in the same cycle wins so no enable request is lost
  assign next_enable = ((irq_enable & ~clr_word) | set_word) & IMPL_MASK;

  // bit mapping
  // bit n of the word is the enable of line 32 + n, no reshuffle;
  // hole positions get a flop too, but their next value is always
  // zero, so synthesis can drop them
  for (genvar b = 0; b < $bits(irq_enable); b++) begin : g_line
    always_ff @(posedge clk) begin
      if (!nrst) begin
        irq_enable[b] <= RESET_ENABLE[b];
      end else begin
        irq_enable[b] <= next_enable[b];
      end
    end
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  // one wait state: ready rises on the second access cycle
  // limitation: a master that drops the access early gets no answer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  // read enables
  // data latched with ready, so it stands for the completing edge;
  // it is zero outside that cycle so stale enables never linger
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata <= RESET_RDATA;
    end else if (access && !pready && !bus_req.pwrite &&
                 (hit_clr || hit_set)) begin
      prdata <= irq_enable & IMPL_MASK;
    end else begin
      prdata <= RESET_RDATA;
    end
  end

  // unmapped offsets answer with an error, nothing changes
  // the error never blocks the set pulses of the companion bank
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access & ~pready & ~(hit_clr | hit_set);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // all checks run on the core clock, and all but a_reset_zero sleep through reset;
  // helper terms below keep the set pulses out of the clear checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // no companion set pulse in this cycle, so a clear check
  // cannot be spoiled by a set that wins over it
  logic quiet_set;
  assign quiet_set = (irq_enable_set_bits == 32'h0000_0000);

  // completing clear write, nothing set beside it
  sequence clr_write_s;
    wr_clr && quiet_set;
  endsequence

  // completing read of the clear bank
  sequence rd_clr_done_s;
    done && !bus_req.pwrite && hit_clr;
  endsequence

  // completing read of the set bank
  sequence rd_set_done_s;
    done && !bus_req.pwrite && hit_set;
  endsequence

  // completing set write
  sequence set_write_s;
    wr_set;
  endsequence

  // completing access to an unmapped offset
  sequence err_done_s;
    done && !(hit_clr || hit_set);
  endsequence

  // clear write, quiet cycle, then a back-to-back read of the bank
  sequence clr_then_read_s;
    clr_write_s ##1 quiet_set ##2 rd_clr_done_s;
  endsequence

  // every written one clears its line
  a_clear_ones: assert property (
    clr_write_s |=> (irq_enable & $past(bus_req.pwdata) & IMPL_MASK) == 0)
    else $error("written one did not clear enable");

  // lines under written zeros stay put
  a_zero_keeps: assert property (
    clr_write_s |=> ((irq_enable ^ $past(irq_enable))
                     & ~$past(bus_req.pwdata)) == 0)
    else $error("written zero changed an enable");

  // read data is the enable state before the answer
  a_read_state: assert property (
    $past(quiet_set) && $past(!wr_set) ##0 rd_clr_done_s
      |-> prdata == ($past(irq_enable) & IMPL_MASK))
    else $error("read data differs from enable state");

  // top pair follows bits 27:26
  a_high_pair: assert property (
    clr_write_s ##0 (bus_req.pwdata[27:26] == 2'b11)
      |=> (irq_enable & HIGH_PAIR) == 0)
    else $error("lines 59:58 not cleared by bits 27:26");

  // middle field follows bits 23:5
  a_mid_field: assert property (
    clr_write_s ##0 ((bus_req.pwdata & MID_FIELD) == MID_FIELD)
      |=> (irq_enable & MID_FIELD) == 0)
    else $error("lines 55:37 not cleared by bits 23:5");

  // low field follows bits 3:0
  a_low_field: assert property (
    clr_write_s ##0 ((bus_req.pwdata & LOW_FIELD) == LOW_FIELD)
      |=> (irq_enable & LOW_FIELD) == 0)
    else $error("lines 35:32 not cleared by bits 3:0");

  // hole positions never hold an enable
  a_hole_bits: assert property (
    (irq_enable & ~IMPL_MASK) == 0)
    else $error("unimplemented enable bit set");

  // exactly one wait state, ready for one cycle
  a_ready_wait: assert property (
    access && !pready |=> pready [*1] ##1 !pready)
    else $error("ready not a one-cycle answer");

  // zeros in the top pair keep those two lines
  a_high_keep: assert property (
    clr_write_s ##0 ((bus_req.pwdata & HIGH_PAIR) == 0)
      |=> (irq_enable & HIGH_PAIR) == ($past(irq_enable) & HIGH_PAIR))
    else $error("lines 59:58 changed by a zero write");

  // zeros in the middle field keep those lines
  a_mid_keep: assert property (
    clr_write_s ##0 ((bus_req.pwdata & MID_FIELD) == 0)
      |=> (irq_enable & MID_FIELD) == ($past(irq_enable) & MID_FIELD))
    else $error("lines 55:37 changed by a zero write");

  // zeros in the low field keep those lines
  a_low_keep: assert property (
    clr_write_s ##0 ((bus_req.pwdata & LOW_FIELD) == 0)
      |=> (irq_enable & LOW_FIELD) == ($past(irq_enable) & LOW_FIELD))
    else $error("lines 35:32 changed by a zero write");

  // a cleared line reads back as zero at once
  a_clear_read: assert property (
    clr_then_read_s
      |-> (prdata & $past(bus_req.pwdata, 3) & IMPL_MASK) == 0)
    else $error("read after clear shows a cleared line");

  // a set pulse reaches its enable one cycle later
  a_set_pulse: assert property (
    !quiet_set
      |=> (irq_enable & $past(irq_enable_set_bits & IMPL_MASK))
          == $past(irq_enable_set_bits & IMPL_MASK))
    else $error("set pulse did not enable its line");

  // a set write reaches its enables one cycle later
  a_set_write: assert property (
    set_write_s
      |=> (irq_enable & $past(bus_req.pwdata & IMPL_MASK))
          == $past(bus_req.pwdata & IMPL_MASK))
    else $error("set write did not enable its lines");

  // refused access leaves every enable alone
  a_err_keeps: assert property (
    err_done_s ##0 quiet_set
      |=> irq_enable == $past(irq_enable))
    else $error("refused access changed an enable");

  // error only ever comes with ready
  a_err_ready: assert property (
    pslverr |-> pready)
    else $error("error raised without ready");

  // refused read returns zero
  a_err_data: assert property (
    pslverr |-> prdata == 0)
    else $error("refused access returned data");

  // read data is zero outside the answer cycle
  a_rdata_idle: assert property (
    !pready |-> prdata == 0)
    else $error("read data outside the answer cycle");

  // hole bits always read as zero
  a_rdata_holes: assert property (
    (prdata & ~IMPL_MASK) == 0)
    else $error("unimplemented bit read as one");

  // set bank read shows the same enables
  a_set_read: assert property (
    rd_set_done_s
      |-> prdata == ($past(irq_enable) & IMPL_MASK))
    else $error("set bank read differs from enable state");

  // mapped offsets are never refused
  a_mapped_ok: assert property (
    done && (hit_clr || hit_set) |-> !pslverr)
    else $error("mapped offset refused");

  // with no write and no set, enables hold
  a_idle_hold: assert property (
    !wr_clr && !wr_set && quiet_set
      |=> $stable(irq_enable))
    else $error("enable changed with no request");

  // reset clears every output; the default disable is switched off
  // here on purpose, so the check runs through the reset itself
  a_reset_zero: assert property (disable iff (1'b0)
    !nrst |=> irq_enable == 0 && !pready && prdata == 0 && !pslverr)
    else $error("outputs not cleared by reset");

  // ready is a single pulse, so a held access cannot complete twice
  // without passing through a fresh wait state
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held for two cycles");

endmodule : iceb_clear_bank

// ---- test/iceb_clear_bank_tb.sv ----
// testbench: register checks of the interrupt clear-enable bank
module iceb_clear_bank_tb;
  import iceb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] M = 32'h0CFF_FFEF;
  logic          clk, nrst, pready, pslverr, err;
  logic [31:0]   prdata, irq_enable, set_bits, rd;
  iceb_bus_req_t req;
  int            failures, comparisons;
  // clear word beside the read-back it should leave
  logic [31:0]   rows [6][2] = '{'{32'h0C00_0000, M & ~32'h0C00_0000},
    '{32'h00FF_FFE0, M & ~32'h00FF_FFE0}, '{32'h0000_000F, M & ~32'hF},
    '{32'h0000_0020, M & ~32'h20}, '{32'h0, M}, '{32'hF300_0010, M}};

  iceb_clear_bank iceb_clear_bank_i (.clk(clk), .nrst(nrst),
    .bus_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq_enable_set_bits(set_bits), .irq_enable(irq_enable));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; request held until pready is seen, bounded wait
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) failures++;
    rd = prdata;
    err = pslverr;
  endtask : xfer

  task automatic wrap_up();
    $display("counts: %0d failures, %0d comparisons", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // watchdog: the tests need a few microseconds at most
  initial begin
    #20us;
    failures++;
    wrap_up();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    req = '0; set_bits = '0; nrst = 1'b0; failures = 0; comparisons = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk(irq_enable, 32'h0);
    foreach (rows[i]) begin
      xfer(1'b1, OFF_ENABLE_TWO, 32'hFFFF_FFFF);
      xfer(1'b1, OFF_DISABLE_TWO, rows[i][0]);
      xfer(1'b0, OFF_DISABLE_TWO, 32'h0);
      chk(rd, rows[i][1]);
      chk({31'h0, err}, 32'h0);
      chk(irq_enable, rows[i][1]);
      $display("row %0d done", i);
    end
    // hardware set pulse onto a cleared bank, line 35
    xfer(1'b1, OFF_DISABLE_TWO, 32'hFFFF_FFFF);
    req <= '0;
    set_bits <= 32'h0000_0008;
    @(posedge clk);
    set_bits <= 32'h0;
    @(posedge clk);
    chk(irq_enable, 32'h8);
    // set bank offset reads back the same enables
    xfer(1'b0, OFF_ENABLE_TWO, 32'h0);
    chk(rd, 32'h8);
    chk({31'h0, err}, 32'h0);
    // unmapped offset is refused and clears nothing
    xfer(1'b1, 12'h008, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    xfer(1'b0, OFF_DISABLE_TWO, 32'h0);
    chk(rd, 32'h8);
    $display("refusal test done");
    // reset in mid-run drops every enable
    req <= '0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk(irq_enable, 32'h0);
    chk({30'h0, pready, pslverr}, 32'h0);
    chk(prdata, 32'h0);
    $display("reset test done");
    wrap_up();
  end
endmodule : iceb_clear_bank_tb
